//--- verilog/sbp_map.vh
`ifndef SBP_MAP_VH
`define SBP_MAP_VH
// Function
// - idle bus seen only after select and busy false one settle delay
// - release every driven line within clear delay once idle holds
// - wait one bus free delay after idle before driving any line
// - contend with busy plus own id line; not after bus set delay (age clears while idle holds, so a late start still arbitrates)
// - after arbitration delay sample data; higher id wins, line 7 highest
// - winner asserts select; loser releases within clear delay of select
// - winner holds all lines unchanged for clear plus settle delay
// - selected when select, own id, no busy, no direction for settle
// - selection carrying only our id bit is still accepted
// - selection must still be valid when busy response is asserted
// - reselect after winning: assert direction, drive or of ids, wait settle
// - on busy answer assert busy, wait two deskew, drop select
// - at most three reselection attempts with timeout release procedure
// - phase code msg,cd,io; 100 and 101 unused; io high to initiator
// - only drive sets phase lines; releasing all lines ends connection
// - one byte per handshake; busy high and select low during transfer
// - phase lines stable settle delay before first request until ack low
// - bus settle delay is 400 ns
// - bus clear delay is 800 ns
// - deskew delay is at least 45 ns
// - selection abort time is at most 200 us
`define SBP_CLK_NS 20
`define SBP_SETTLE_NS 400
`define SBP_CLEAR_NS 800
`define SBP_DESKEW_NS 45
`define SBP_FREE_NS 400
`define SBP_BUSSET_NS 1800
`define SBP_ARB_NS 2200
`define SBP_ABORT_US 200
`define SBP_SELTO_MS 250
`define SBP_SETTLE_CYC ((`SBP_SETTLE_NS + `SBP_CLK_NS - 1) / `SBP_CLK_NS)
`define SBP_CLEAR_CYC (`SBP_CLEAR_NS / `SBP_CLK_NS)
`define SBP_DESKEW_CYC ((`SBP_DESKEW_NS + `SBP_CLK_NS - 1) / `SBP_CLK_NS)
`define SBP_FREE_CYC ((`SBP_FREE_NS + `SBP_CLK_NS - 1) / `SBP_CLK_NS)
`define SBP_BUSSET_CYC (`SBP_BUSSET_NS / `SBP_CLK_NS)
`define SBP_ARB_CYC ((`SBP_ARB_NS + `SBP_CLK_NS - 1) / `SBP_CLK_NS)
`define SBP_ABORT_CYC (`SBP_ABORT_US * 1000 / `SBP_CLK_NS)
`define SBP_SELTO_CYC (`SBP_SELTO_MS * 1000000 / `SBP_CLK_NS)
`define SBP_RESEL_TRIES 2'h3
`define SBP_PH_DOUT 3'h0
`define SBP_PH_DIN 3'h1
`define SBP_PH_CMD 3'h2
`define SBP_PH_STAT 3'h3
`define SBP_PH_MOUT 3'h6
`define SBP_PH_MIN 3'h7
`endif

//--- verilog/sbp_stable.v
`timescale 1ns/1ns
// counts cycles a condition has held without a break
module sbp_stable #(
  parameter W = 24
) (
  input wire mclk, // clock
  input wire rst_n, // sync reset
  input wire ce, // clock enable
  input wire cond, // watched condition
  input wire [W-1:0] lim, // cycles needed
  output wire held // cond held for lim cycles
);
  reg [W-1:0] cnt_ff;
  // saturating run-length counter, any break restarts it
  always @(posedge mclk) begin
    if (!rst_n) begin
      cnt_ff <= {W{1'b0}};
    end else if (ce) begin
      if (!cond) begin
        cnt_ff <= {W{1'b0}};
      end else if (cnt_ff != lim) begin
        cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
  assign held = cond && (cnt_ff == lim);
endmodule // sbp_stable

//--- verilog/sbp_idpop.v
`timescale 1ns/1ns
// id-bit checks on the data lines
module sbp_idpop (
  input wire [7:0] db, // data lines, true high
  input wire [2:0] own_id, // our bus address
  output wire own_set, // our bit true
  output wire higher, // a higher id bit true
  output wire le_two // at most two bits true
);
  wire [7:0] own_mask;
  wire [7:0] hi_mask;
  reg [3:0] pop;
  integer i;
  assign own_mask = 8'h01 << own_id;
  assign hi_mask = ~((own_mask << 1) - 8'h01); // bits above own
  // population count for the two-bit limit
  always @* begin
    pop = 4'h0;
    for (i = 0; i < 8; i = i + 1) begin
      pop = pop + {3'h0, db[i]};
    end
  end
  assign own_set = |(db & own_mask);
  assign higher = |(db & hi_mask & ~own_mask); // line 7 highest
  assign le_two = (pop <= 4'h2);
endmodule // sbp_idpop

//--- verilog/sbp_phase_ctl.v
`timescale 1ns/1ns
`include "sbp_map.vh"
// bus phase control: bus free, arbitration, selection, reselection, phases
module sbp_phase_ctl #(
  parameter [31:0] ABORT_CYC = `SBP_ABORT_CYC, // selection abort time
  parameter [31:0] SELTO_CYC = `SBP_SELTO_CYC // selection timeout delay
) (
  input wire mclk, // 50 MHz clock
  input wire rst_n, // sync reset, active low
  input wire ce, // clock enable
  input wire [2:0] own_id, // our bus address
  input wire bsy_in, // busy line level
  input wire sel_in, // select line level
  input wire io_in, // direction line level
  input wire ack_in, // acknowledge line level
  input wire [7:0] db_in, // data line levels
  input wire resel_req, // pulse: start reselection
  input wire [2:0] resel_init_id, // initiator to reselect
  input wire phase_req, // pulse: enter transfer phase
  input wire [2:0] phase_code, // msg,cd,io requested
  input wire xfer_go, // level: handshakes may run
  input wire xfer_last, // level: current phase done
  input wire release_req, // pulse: end the connection
  output reg bsy_oe_ff, // drive busy
  output reg sel_oe_ff, // drive select
  output reg msg_oe_ff, // drive message line
  output reg cd_oe_ff, // drive control/data line
  output reg io_oe_ff, // drive direction line
  output reg [7:0] db_oe_ff, // drive data bits true
  output reg bus_free_ff, // bus idle detected
  output reg selected_ff, // pulse: we were selected
  output reg connected_ff, // we own the bus as target
  output reg resel_fail_ff, // pulse: all attempts failed
  output reg [1:0] tries_ff, // reselection attempts released after timeout
  output wire req_ok, // phase lines settled
  output reg [3:0] state_ff // current state
);
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_FREE = 4'h1;
  localparam [3:0] S_ARB = 4'h2;
  localparam [3:0] S_WIN = 4'h3;
  localparam [3:0] S_RSEL = 4'h4;
  localparam [3:0] S_RWAIT = 4'h5;
  localparam [3:0] S_RBSY = 4'h6;
  localparam [3:0] S_RTO = 4'h7;
  localparam [3:0] S_SELCHK = 4'h8;
  localparam [3:0] S_CONN = 4'h9;
  localparam [3:0] S_PSET = 4'hA;
  localparam [3:0] S_PXFER = 4'hB;
  localparam [23:0] SETTLE_C = `SBP_SETTLE_CYC;
  localparam [23:0] CLEAR_C = `SBP_CLEAR_CYC;
  localparam [23:0] DESKEW_C = `SBP_DESKEW_CYC;
  localparam [23:0] FREE_C = `SBP_FREE_CYC;
  localparam [23:0] BUSSET_C = `SBP_BUSSET_CYC;
  localparam [23:0] ARB_C = `SBP_ARB_CYC;
  localparam [23:0] ABORT_C = ABORT_CYC[23:0];
  localparam [23:0] SELTO_C = SELTO_CYC[23:0];
  wire idle_held;
  wire sel_held;
  wire sel_cond;
  wire own_set;
  wire higher;
  wire le_two;
  wire [7:0] own_mask;
  wire [7:0] ini_mask;
  reg [3:0] nxt_state;
  reg [23:0] tmr_ff;
  reg [23:0] free_age_ff;
  reg [2:0] cur_phase_ff;
  reg resel_req_ff;
  reg tmr_clr;
  assign own_mask = 8'h01 << own_id;
  assign ini_mask = 8'h01 << resel_init_id;
  // bus idle: select and busy false for an unbroken settle delay
  sbp_stable #(.W(24)) u_idle (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .cond(!bsy_in && !sel_in),
    .lim(SETTLE_C),
    .held(idle_held)
  );
  // selection seen: select, own id, no busy, no direction for settle
  assign sel_cond = sel_in && own_set && !bsy_in && !io_in && le_two;
  sbp_stable #(.W(24)) u_sel (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .cond(sel_cond),
    .lim(SETTLE_C),
    .held(sel_held)
  );
  sbp_idpop u_pop (
    .db(db_in),
    .own_id(own_id),
    .own_set(own_set),
    .higher(higher),
    .le_two(le_two)
  );
  // next state; timer restarts whenever the state changes
  always @* begin
    nxt_state = state_ff;
    tmr_clr = 1'b0;
    case (state_ff)
      S_IDLE: begin
        if (sel_held) begin
          nxt_state = S_SELCHK; // at most two id bits set, ours among them
        end else if (idle_held) begin
          nxt_state = S_FREE;
        end
      end
      S_FREE: begin
        if (!idle_held) begin
          nxt_state = S_IDLE;
        end else if (resel_req_ff && tmr_ff >= FREE_C && free_age_ff <= BUSSET_C) begin
          nxt_state = S_ARB;
        end
      end
      S_ARB: begin
        if (sel_in) begin
          nxt_state = S_IDLE; // someone else won: release
        end else if (tmr_ff >= ARB_C) begin
          nxt_state = higher ? S_IDLE : S_WIN;
        end
      end
      S_WIN: begin
        if (tmr_ff >= CLEAR_C + SETTLE_C) begin
          nxt_state = S_RSEL;
        end
      end
      S_RSEL: begin
        if (tmr_ff >= SETTLE_C) begin
          nxt_state = S_RWAIT;
        end
      end
      S_RWAIT: begin
        if (bsy_in) begin
          nxt_state = S_RBSY;
        end else if (tmr_ff >= SELTO_C) begin
          nxt_state = S_RTO;
        end
      end
      S_RBSY: begin
        if (tmr_ff >= DESKEW_C + DESKEW_C) begin
          nxt_state = S_CONN;
        end
      end
      S_RTO: begin
        if (bsy_in) begin
          nxt_state = S_RBSY;
        end else if (tmr_ff >= ABORT_C + DESKEW_C + DESKEW_C) begin
          nxt_state = S_IDLE;
        end
      end
      S_SELCHK: begin
        // busy already asserted; connect once select drops, give up if it stays past the abort time
        if (!sel_in) begin
          nxt_state = S_CONN;
        end else if (tmr_ff >= ABORT_C) begin
          nxt_state = S_IDLE;
        end
      end
      S_CONN: begin
        if (release_req) begin
          nxt_state = S_IDLE;
        end else if (phase_req && phase_code[2:1] != 2'h2) begin
          nxt_state = S_PSET; // unused codes refused
        end
      end
      S_PSET: begin
        if (tmr_ff >= SETTLE_C) begin
          nxt_state = S_PXFER;
        end
      end
      S_PXFER: begin
        if (xfer_last && !ack_in) begin
          nxt_state = S_CONN;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
    if (nxt_state != state_ff) begin
      tmr_clr = 1'b1;
    end
  end
  reg [7:0] nxt_db;
  reg nxt_bsy;
  reg nxt_sel;
  reg nxt_io;
  reg [2:0] nxt_ph;
  // line drive per state; idle states drive nothing
  always @* begin
    nxt_db = 8'h00;
    nxt_bsy = 1'b0;
    nxt_sel = 1'b0;
    nxt_io = 1'b0;
    nxt_ph = 3'h0;
    case (nxt_state)
      S_ARB: begin
        nxt_bsy = 1'b1;
        nxt_db = own_mask;
      end
      S_WIN: begin
        nxt_bsy = 1'b1;
        nxt_sel = 1'b1;
        nxt_db = own_mask;
      end
      S_RSEL, S_RWAIT: begin
        nxt_bsy = (nxt_state == S_RSEL) ? 1'b1 : 1'b0; // busy dropped to await answer
        nxt_sel = 1'b1;
        nxt_io = 1'b1;
        nxt_db = own_mask | ini_mask;
      end
      S_RTO: begin
        nxt_sel = 1'b1;
        nxt_io = 1'b1; // data released
      end
      S_RBSY: begin
        nxt_bsy = 1'b1;
        nxt_sel = 1'b1;
        nxt_io = 1'b1;
        nxt_db = own_mask | ini_mask;
      end
      S_SELCHK, S_CONN: begin
        nxt_bsy = 1'b1;
        nxt_ph = cur_phase_ff;
        nxt_io = cur_phase_ff[0];
      end
      S_PSET, S_PXFER: begin
        nxt_bsy = 1'b1; // select stays low
        nxt_ph = (state_ff == S_CONN) ? phase_code : cur_phase_ff;
        nxt_io = nxt_ph[0];
      end
      default: begin
        nxt_bsy = 1'b0;
      end
    endcase
  end
  // state, timers and line registers
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      tmr_ff <= 24'h000000;
      free_age_ff <= 24'h000000;
      cur_phase_ff <= 3'h0;
      resel_req_ff <= 1'b0;
      bsy_oe_ff <= 1'b0;
      sel_oe_ff <= 1'b0;
      msg_oe_ff <= 1'b0;
      cd_oe_ff <= 1'b0;
      io_oe_ff <= 1'b0;
      db_oe_ff <= 8'h00;
      bus_free_ff <= 1'b0;
      selected_ff <= 1'b0;
      connected_ff <= 1'b0;
      resel_fail_ff <= 1'b0;
      tries_ff <= 2'h0;
    end else if (ce) begin
      state_ff <= nxt_state;
      tmr_ff <= tmr_clr ? 24'h000000 : (tmr_ff == 24'hFFFFFF ? tmr_ff : tmr_ff + 24'h000001);
      // age since idle last seen; a quiet bus keeps it fresh, so a late request never deadlocks
      free_age_ff <= idle_held ? 24'h000000 : free_age_ff + {23'h0, free_age_ff != 24'hFFFFFF};
      bsy_oe_ff <= nxt_bsy;
      sel_oe_ff <= nxt_sel;
      io_oe_ff <= nxt_io;
      msg_oe_ff <= nxt_ph[2];
      cd_oe_ff <= nxt_ph[1];
      db_oe_ff <= nxt_db;
      bus_free_ff <= idle_held;
      selected_ff <= (state_ff == S_IDLE) && (nxt_state == S_SELCHK);
      connected_ff <= (nxt_state == S_CONN) || (nxt_state == S_PSET) || (nxt_state == S_PXFER);
      if (state_ff == S_CONN && nxt_state == S_PSET) begin
        cur_phase_ff <= phase_code;
      end else if (nxt_state == S_IDLE) begin
        cur_phase_ff <= 3'h0;
      end
      // request held until an attempt sequence ends
      resel_fail_ff <= 1'b0;
      if (resel_req && state_ff != S_CONN) begin
        resel_req_ff <= 1'b1;
        tries_ff <= 2'h0;
      end else if (state_ff == S_RTO && nxt_state == S_IDLE) begin
        if (tries_ff + 2'h1 == `SBP_RESEL_TRIES) begin
          resel_req_ff <= 1'b0; // three attempts made
          resel_fail_ff <= 1'b1;
        end
        tries_ff <= tries_ff + 2'h1;
      end else if (nxt_state == S_CONN && state_ff == S_RBSY) begin
        resel_req_ff <= 1'b0;
      end
    end
  end
  // handshakes allowed only after phase lines settled
  assign req_ok = (state_ff == S_PXFER) && xfer_go;
endmodule // sbp_phase_ctl

//--- bench/sbp_phase_ctl_sva.sv
`timescale 1ns/1ns
// bus timing checks at the block ports
module sbp_phase_ctl_chk (
  input wire mclk, // clock
  input wire rst_n, // sync reset
  input wire [2:0] own_id, // our id
  input wire [2:0] resel_init_id, // reselected initiator
  input wire bsy_in, // busy level
  input wire sel_in, // select level
  input wire io_in, // direction level
  input wire ack_in, // ack level
  input wire [7:0] db_in, // data levels
  input wire bsy_oe_ff, // drive busy
  input wire sel_oe_ff, // drive select
  input wire msg_oe_ff, // drive message
  input wire cd_oe_ff, // drive control/data
  input wire io_oe_ff, // drive direction
  input wire [7:0] db_oe_ff, // drive data
  input wire connected_ff, // target owns bus
  input wire req_ok // phase settled
);
  reg [7:0] idle_ff, bsyc_ff, wsel_ff, vsel_ff, bin_ff, phc_ff;
  reg [2:0] php_ff;
  wire [2:0] ph = {msg_oe_ff, cd_oe_ff, io_oe_ff};
  wire vsel = sel_in & db_in[own_id] & !bsy_in & !io_in & ($countones(db_in) <= 2);
  // saturating run length, so long waits never wrap
  function [7:0] inc(input [7:0] c, input hold);
    inc = !hold ? 8'h00 : (c == 8'hFF) ? c : c + 8'h01;
  endfunction
  // run lengths of the conditions the bus delays are measured on
  always @(posedge mclk) begin
    if (!rst_n) begin
      idle_ff <= 8'h00;
      bsyc_ff <= 8'h00;
      wsel_ff <= 8'h00;
      vsel_ff <= 8'h00;
      bin_ff <= 8'h00;
      phc_ff <= 8'h00;
      php_ff <= 3'h0;
    end else begin
      idle_ff <= inc(idle_ff, !bsy_in && !sel_in);
      bsyc_ff <= inc(bsyc_ff, bsy_oe_ff);
      wsel_ff <= inc(wsel_ff, sel_oe_ff);
      vsel_ff <= inc(vsel_ff, vsel);
      bin_ff <= inc(bin_ff, bsy_in);
      phc_ff <= (ph == php_ff) ? inc(phc_ff, 1'b1) : 8'h01;
      php_ff <= ph;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_ARB_ENTRY: assert property ($rose(bsy_oe_ff) && !sel_in |->
    db_oe_ff == (8'h01 << own_id) && idle_ff >= 8'h28 && $past(!bsy_in && !sel_in))
    else $error("arbitration entry bad");
  AST_ARB_WAIT: assert property ($rose(sel_oe_ff) |-> bsyc_ff >= 8'h6E)
    else $error("select before arbitration delay");
  AST_LOSE: assert property ($rose(sel_in) && bsy_oe_ff && !sel_oe_ff |->
    ##[0:40] (!bsy_oe_ff && db_oe_ff == 8'h00)) else $error("loser kept lines");
  AST_WIN_HOLD: assert property (sel_oe_ff && wsel_ff != 8'h00 && wsel_ff < 8'h3C |->
    $stable(db_oe_ff) && bsy_oe_ff && !io_oe_ff) else $error("winner changed lines");
  AST_SEL_VALID: assert property ($rose(bsy_oe_ff) && sel_in && !sel_oe_ff |->
    vsel_ff >= 8'h14) else $error("busy on invalid selection");
  AST_RESEL_OR: assert property ($rose(io_oe_ff) && sel_oe_ff |-> bsy_oe_ff &&
    db_oe_ff == ((8'h01 << own_id) | (8'h01 << resel_init_id))) else $error("resel data bad");
  AST_RESEL_DESKEW: assert property ($fell(sel_oe_ff) && bsy_in |->
    bsy_oe_ff && bin_ff >= 8'h06) else $error("select dropped early");
  AST_RESEL_TIMEOUT: assert property ($fell(sel_oe_ff) && !bsy_in |->
    !io_oe_ff && $past(db_oe_ff) == 8'h00) else $error("timeout release bad");
  AST_XFER_BUS: assert property (req_ok |-> bsy_oe_ff && !sel_oe_ff)
    else $error("transfer without busy");
  AST_REQ_SETTLE: assert property ($rose(req_ok) |-> phc_ff >= 8'h14)
    else $error("request before settle");
  AST_PH_HOLD: assert property (connected_ff && ack_in |=> $stable(ph))
    else $error("phase moved during ack");
  COV_CONNECT: cover property ($rose(connected_ff));
  COV_RESEL: cover property ($rose(io_oe_ff) && sel_oe_ff);
  COV_LOSE: cover property ($fell(bsy_oe_ff) && !sel_oe_ff && !connected_ff);
endmodule // sbp_phase_ctl_chk

bind sbp_phase_ctl sbp_phase_ctl_chk i_sbp_phase_ctl_chk (.mclk, .rst_n, .own_id,
  .resel_init_id, .bsy_in, .sel_in, .io_in, .ack_in, .db_in, .bsy_oe_ff, .sel_oe_ff,
  .msg_oe_ff, .cd_oe_ff, .io_oe_ff, .db_oe_ff, .connected_ff, .req_ok);

//--- bench/sbp_init_model.sv
`timescale 1ns/1ns
// far-side initiator: selects the drive, answers reselection, acks bytes
module sbp_init_model #(
  parameter SELTO = 500,
  parameter ABORT = 200
) (
  input wire mclk, // clock
  input wire rst_n, // sync reset
  input wire bsy_in, // busy level
  input wire sel_in, // select level
  input wire io_in, // direction level
  input wire [7:0] db_in, // data levels
  input wire req_ok, // byte may move
  input wire sel_go, // pulse: select
  input wire [7:0] sel_db, // ids to drive
  input wire ans_en, // answer reselection
  input wire [2:0] my_id, // our id
  output reg bsy_ff, // drive busy
  output reg sel_ff, // drive select
  output reg [7:0] db_ff, // drive data
  output reg ack_ff // drive ack
);
  reg [2:0] st_ff;
  reg [15:0] cnt_ff;
  reg [7:0] icnt_ff, rcnt_ff;
  wire rsel = sel_in & io_in & db_in[my_id] & !bsy_in & ($countones(db_in) <= 2);
  // released lines read false on the bus, as the terminators pull them
  always @(posedge mclk) begin
    if (!rst_n) begin
      {st_ff, cnt_ff, icnt_ff, rcnt_ff} <= 35'h0;
      {bsy_ff, sel_ff, db_ff, ack_ff} <= 11'h000;
    end else begin
      icnt_ff <= (bsy_in | sel_in) ? 8'h00 : icnt_ff + {7'h00, icnt_ff != 8'hFF};
      rcnt_ff <= rsel ? rcnt_ff + {7'h00, rcnt_ff != 8'hFF} : 8'h00;
      cnt_ff <= cnt_ff + 16'h0001;
      case (st_ff)
        3'h0: begin
          cnt_ff <= 16'h0000;
          if (sel_go) st_ff <= 3'h1;
        end
        3'h1: if (icnt_ff >= 8'h3C) begin // idle then a clear delay
          db_ff <= sel_db;
          cnt_ff <= 16'h0000;
          st_ff <= 3'h2;
        end
        3'h2: if (cnt_ff == 16'h0005) begin // two deskews to select
          sel_ff <= 1'b1;
          cnt_ff <= 16'h0000;
          st_ff <= 3'h3;
        end
        3'h3: if (bsy_in) begin
          cnt_ff <= 16'h0000;
          st_ff <= 3'h4;
        end else if (cnt_ff == SELTO) begin // keep select, drop data
          db_ff <= 8'h00;
        end else if (cnt_ff == SELTO + ABORT + 6) begin
          sel_ff <= 1'b0;
          st_ff <= 3'h0;
        end
        default: if (cnt_ff == 16'h0005) begin
          {sel_ff, db_ff} <= 9'h000;
          st_ff <= 3'h0;
        end
      endcase
      // answer only a still valid reselection, drop busy once select goes
      if (ans_en && rcnt_ff >= 8'h14) bsy_ff <= 1'b1;
      else if (!sel_in) bsy_ff <= 1'b0;
      ack_ff <= req_ok & !ack_ff; // one byte per handshake
    end
  end
endmodule // sbp_init_model

//--- bench/test_sbp_phase_ctl.sv
`timescale 1ns/1ns
module test_sbp_phase_ctl;
  reg mclk, rst_n, resel_req, phase_req, xfer_go, xfer_last, release_req;
  reg t_bsy, t_sel, sel_go, ans_en;
  reg [2:0] own_id, resel_init_id, phase_code;
  reg [7:0] t_db, sel_db;
  reg [31:0] rng;
  integer miscompares, num_checks, n, k;
  wire bsy_oe_ff, sel_oe_ff, msg_oe_ff, cd_oe_ff, io_oe_ff, bus_free_ff, selected_ff;
  wire connected_ff, resel_fail_ff, req_ok, p_bsy, p_sel, p_ack;
  wire [7:0] db_oe_ff, p_db;
  wire [1:0] tries_ff;
  // wired-or bus lines
  wire bsy = bsy_oe_ff | p_bsy | t_bsy;
  wire sel = sel_oe_ff | p_sel | t_sel;
  wire [7:0] db = db_oe_ff | p_db | t_db;
  wire [2:0] ph = {msg_oe_ff, cd_oe_ff, io_oe_ff};
  wire [4:0] ev = {req_ok, resel_fail_ff, connected_ff, selected_ff, bus_free_ff};
  // short timeouts keep the run small
  sbp_phase_ctl #(.ABORT_CYC(32'h000000C8), .SELTO_CYC(32'h000001F4)) i_sbp_phase_ctl (
    .mclk(mclk), .rst_n(rst_n), .ce(1'b1), .own_id(own_id), .bsy_in(bsy), .sel_in(sel),
    .io_in(io_oe_ff), .ack_in(p_ack), .db_in(db), .resel_req(resel_req),
    .resel_init_id(resel_init_id), .phase_req(phase_req), .phase_code(phase_code),
    .xfer_go(xfer_go), .xfer_last(xfer_last), .release_req(release_req),
    .bsy_oe_ff(bsy_oe_ff), .sel_oe_ff(sel_oe_ff), .msg_oe_ff(msg_oe_ff), .cd_oe_ff(cd_oe_ff),
    .io_oe_ff(io_oe_ff), .db_oe_ff(db_oe_ff), .bus_free_ff(bus_free_ff),
    .selected_ff(selected_ff), .connected_ff(connected_ff), .resel_fail_ff(resel_fail_ff),
    .tries_ff(tries_ff), .req_ok(req_ok), .state_ff());
  sbp_init_model #(.SELTO(500), .ABORT(200)) i_sbp_init_model (.mclk(mclk), .rst_n(rst_n),
    .bsy_in(bsy), .sel_in(sel), .io_in(io_oe_ff), .db_in(db), .req_ok(req_ok),
    .sel_go(sel_go), .sel_db(sel_db), .ans_en(ans_en), .my_id(resel_init_id),
    .bsy_ff(p_bsy), .sel_ff(p_sel), .db_ff(p_db), .ack_ff(p_ack));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // unused codes leave the phase lines alone
  function [2:0] exp_ph(input [2:0] cur, input [2:0] code);
    exp_ph = (code == 3'h4 || code == 3'h5) ? cur : code;
  endfunction
  task end_sim;
    begin
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [63:0] exp, input [63:0] got, input [8*10:1] what);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("ERROR %0s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  // inputs move 2 ns after the edge
  task tick;
    begin
      @(posedge mclk);
      #2;
    end
  endtask
  // bounded wait on one status bit, cycles left in n
  task wait_ev(input integer b, input integer lim);
    begin
      n = 0;
      while (ev[b] !== 1'b1 && n < lim) begin
        tick;
        n = n + 1;
      end
    end
  endtask
  task rel;
    begin
      release_req = 1'b1;
      tick;
      release_req = 1'b0;
      repeat (4) tick;
      chk(0, {bsy_oe_ff, ph, db_oe_ff, connected_ff}, "release");
    end
  endtask
  // every code once, starting from command so the first one is legal
  task phases;
    reg [2:0] cur;
    integer i;
    begin
      cur = 3'h0;
      for (i = 2; i < 10; i = i + 1) begin
        phase_code = i[2:0];
        phase_req = 1'b1;
        tick;
        phase_req = 1'b0;
        repeat (3) tick;
        cur = exp_ph(cur, i[2:0]);
        chk(cur, ph, "phase");
        if (cur == i[2:0]) begin
          rng = xs(rng);
          repeat (rng[2:0]) tick;
          xfer_go = 1'b1;
          wait_ev(4, 60);
          chk(1, n < 60, "req_ok");
          // several handshakes run before the phase is marked done
          repeat (6) tick;
          xfer_last = 1'b1;
          repeat (3) tick;
          {xfer_go, xfer_last} = 2'h0;
        end
      end
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // whole plan is near 5k cycles; six times that means a hang
  initial begin
    #600000;
    miscompares = miscompares + 1;
    end_sim;
  end
  initial begin
    {rst_n, resel_req, phase_req, xfer_go, xfer_last, release_req} = 6'h00;
    {t_bsy, t_sel, sel_go, ans_en, t_db, sel_db} = 20'h00000;
    {own_id, resel_init_id, phase_code} = 9'h000;
    rng = 32'h0000004C;
    miscompares = 0;
    num_checks = 0;
    repeat (2) @(posedge mclk);
    #2;
    rst_n = 1'b1;
    chk(0, {bsy_oe_ff, sel_oe_ff, db_oe_ff}, "reset");
    wait_ev(0, 60);
    chk(1, n >= 20 && n < 25, "idle");
    // selection with both ids, target id only, three ids
    for (k = 0; k < 3; k = k + 1) begin
      rng = xs(rng);
      own_id = rng[2:0];
      sel_db = (8'h01 << own_id) | ((k != 1) ? 8'h01 << (own_id ^ 3'h4) : 8'h00);
      sel_db = sel_db | ((k == 2) ? 8'h01 << (own_id ^ 3'h2) : 8'h00);
      sel_go = 1'b1;
      tick;
      sel_go = 1'b0;
      wait_ev(1, 300);
      chk(k != 2, n < 300, "selected");
      if (k != 2) begin
        wait_ev(2, 300);
        chk(1, n < 300, "connect");
        phases;
        rel;
      end
      wait_ev(0, 1200);
    end
    // reselection answered, then never answered
    for (k = 0; k < 2; k = k + 1) begin
      rng = xs(rng);
      own_id = rng[2:0];
      resel_init_id = own_id ^ 3'h1;
      ans_en = (k == 0);
      resel_req = 1'b1;
      tick;
      resel_req = 1'b0;
      wait_ev(k + 2, 6000);
      chk(1, n < 6000, "resel");
      if (k == 0) rel;
      else chk(3, tries_ff, "tries");
      wait_ev(0, 200);
    end
    // contention against id 7, then retry once the bus frees
    own_id = 3'h3;
    resel_init_id = 3'h0;
    ans_en = 1'b1;
    resel_req = 1'b1;
    tick;
    resel_req = 1'b0;
    n = 0;
    while (bsy_oe_ff !== 1'b1 && n < 200) begin
      tick;
      n = n + 1;
    end
    {t_bsy, t_db} = 9'h180;
    repeat (120) tick;
    chk(0, sel_oe_ff, "arb win");
    t_sel = 1'b1;
    n = 0;
    while ((bsy_oe_ff | (|db_oe_ff)) !== 1'b0 && n < 60) begin
      tick;
      n = n + 1;
    end
    chk(1, n <= 40, "arb lose");
    {t_bsy, t_sel, t_db} = 10'h000;
    wait_ev(2, 4000);
    chk(1, n < 4000, "retry");
    rel;
    end_sim;
  end
endmodule // test_sbp_phase_ctl
